// ---- shared/dpu_defs.vh ----
/*
  constants for the debug pin unlock and break block: key bytes, opcodes,
  timing. assumes a 200 MHz mclk.
*/
`ifndef DPU_DEFS_VH
`define DPU_DEFS_VH
`define DPU_AUTOBAUD_BYTE 8'h80
`define DPU_KEY_B0 8'hEB
`define DPU_KEY_B1 8'h5A
`define DPU_KEY_B2 8'h70
`define DPU_KEY_B3 8'hCD
`define DPU_KEY_LEN 3'h4
`define DPU_OPC_BREAK 8'h00
`define DPU_OPC_ILLEGAL 8'hFF
`define DPU_OPC_NOP 8'h0F
`define DPU_CTRL_DEBUG 8'h80
`define DPU_CLK_MHZ 200
`define DPU_RST_SETTLE_MS 5
`define DPU_RST_SETTLE_CYC (`DPU_RST_SETTLE_MS * 1000 * `DPU_CLK_MHZ)
`endif

// ---- rtl/dpu_rx.v ----
/*
  serial byte receiver for the debug line with autobaud and break detect.
  assumes the line input is already synchronous to mclk and idles high.
*/
`default_nettype none
module dpu_rx #(
  parameter CW = 16
) (
  input wire mclk,
  input wire srst,
  input wire line_in,
  input wire rearm,
  output reg baud_ok_q,
  output reg [7:0] byte_q,
  output reg byte_vld_q,
  output reg break_q
);
  reg [CW-1:0] bit_len_q; // cycles per bit from autobaud
  reg [CW-1:0] cnt_q; // general counter
  reg [CW-1:0] low_q; // consecutive low cycles
  reg [3:0] bit_idx_q; // current bit
  reg [1:0] st_q; // receiver state
  reg line_d1_q; // previous line level
  // ten bit times as 8x plus 2x; wraps only for absurdly slow bit rates
  wire [CW-1:0] brk_len;
  assign brk_len = {bit_len_q[CW-4:0], 3'h0} + {bit_len_q[CW-2:0], 1'b0};
  localparam S_IDLE = 2'h0;
  localparam S_BAUD = 2'h1;
  localparam S_DATA = 2'h2;
  localparam S_STOP = 2'h3;

  // low run length, feeds break detection independent of the byte fsm
  always @(posedge mclk) begin
    if (srst) begin
      low_q <= {CW{1'b0}};
      break_q <= 1'b0;
    end else begin
      low_q <= line_in ? {CW{1'b0}} : (&low_q ? low_q : low_q + 1'b1);
      // low longer than ten bits is a break, even mid character
      break_q <= baud_ok_q && !line_in && (low_q == brk_len);
    end
  end

  // autobaud measures start plus seven zero bits of 80h, then bytes
  always @(posedge mclk) begin
    if (srst || rearm) begin
      st_q <= S_IDLE;
      baud_ok_q <= 1'b0;
      bit_len_q <= {CW{1'b0}};
      cnt_q <= {CW{1'b0}};
      bit_idx_q <= 4'h0;
      byte_q <= 8'h00;
      byte_vld_q <= 1'b0;
      line_d1_q <= 1'b1;
    end else begin
      line_d1_q <= line_in;
      byte_vld_q <= 1'b0;
      case (st_q)
        S_IDLE: begin
          // falling edge starts either autobaud or a character
          if (line_d1_q && !line_in) begin
            cnt_q <= {CW{1'b0}};
            st_q <= baud_ok_q ? S_DATA : S_BAUD;
            bit_idx_q <= 4'h0;
          end
        end
        S_BAUD: begin
          cnt_q <= cnt_q + 1'b1;
          if (line_in) begin
            // eight low bit times; divide by eight
            bit_len_q <= {3'h0, cnt_q[CW-1:3]};
            baud_ok_q <= 1'b1;
            st_q <= S_STOP;
          end
        end
        S_DATA: begin
          cnt_q <= cnt_q + 1'b1;
          // sample mid bit; first sample lands mid start bit
          if (cnt_q == (bit_idx_q == 4'h0 ? {1'b0, bit_len_q[CW-1:1]} : bit_len_q)) begin
            cnt_q <= {CW{1'b0}};
            bit_idx_q <= bit_idx_q + 1'b1;
            if (bit_idx_q != 4'h0)
              byte_q <= {line_in, byte_q[7:1]};
            if (bit_idx_q == 4'h8) begin
              byte_vld_q <= 1'b1;
              st_q <= S_STOP;
            end
          end
        end
        S_STOP: begin
          // wait for line high before the next start
          if (line_in)
            st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule // dpu_rx
`default_nettype wire

// ---- rtl/dpu_unlock.v ----
/*
  debug pin unlock and break handling for the small package.
  assumes shared pin input and reset pin level synchronous to mclk; the
  core presents each opcode on fetch_opcode with a one-cycle fetch_vld, and opcode 00h is decoded here as break.
*/
`include "dpu_defs.vh"
`default_nettype none
module dpu_unlock #(
  parameter SMALL_PKG = 1,
  parameter SETTLE_CYC = `DPU_RST_SETTLE_CYC
) (
  input wire mclk,
  input wire srst,
  input wire shared_reset_pin_n,
  input wire shared_debug_gpio_pin_in,
  input wire gpio_out,
  input wire gpio_oe_n,
  input wire ocd_tx_low,
  input wire [7:0] ctrl_wr_data,
  input wire ctrl_wr,
  input wire bp_enable,
  input wire [7:0] fetch_opcode,
  input wire fetch_vld,
  output reg shared_debug_gpio_pin_out,
  output reg shared_debug_gpio_pin_oe_n,
  output wire gpio_in,
  output wire debug_serial_pin,
  output reg pin_unlocked_q,
  output reg debug_mode_q,
  output reg cpu_idle_q,
  output reg [7:0] exec_opcode_q,
  output reg illegal_op_q,
  output reg break_seen_q,
  output reg [7:0] rx_byte_q,
  output reg rx_byte_vld_q
);
  localparam U_WAIT = 3'h0;
  localparam U_BAUD = 3'h1;
  localparam U_KEY = 3'h2;
  localparam U_DONE = 3'h3;
  localparam U_FAIL = 3'h4;
  reg [2:0] ust_q; // unlock state
  reg [2:0] key_idx_q; // key byte index
  reg [31:0] settle_q; // reset settle count
  reg rst_held_q; // reset pin low last cycle
  wire rst_held = !shared_reset_pin_n;
  wire line_in; // what the debug unit sees
  wire rx_baud_ok;
  wire [7:0] rx_byte;
  wire rx_vld;
  wire rx_break;
  reg [7:0] key_byte; // expected key byte

  // debug unit only sees the pin once unlocked
  assign line_in = (SMALL_PKG == 0 || pin_unlocked_q) ? shared_debug_gpio_pin_in : 1'b1;
  assign debug_serial_pin = line_in;
  // gpio input path blinded once the pin belongs to debug
  assign gpio_in = pin_unlocked_q ? 1'b1 : shared_debug_gpio_pin_in;

  // receiver restarts at reset so a fresh autobaud is needed
  dpu_rx #(.CW(16)) u_rx (
    .mclk(mclk),
    .srst(srst),
    .line_in(pin_unlocked_q ? line_in : shared_debug_gpio_pin_in),
    .rearm(rst_held != rst_held_q),
    .baud_ok_q(rx_baud_ok),
    .byte_q(rx_byte),
    .byte_vld_q(rx_vld),
    .break_q(rx_break)
  );

  // key byte select
  always @* begin
    case (key_idx_q)
      3'h0: key_byte = `DPU_KEY_B0;
      3'h1: key_byte = `DPU_KEY_B1;
      3'h2: key_byte = `DPU_KEY_B2;
      3'h3: key_byte = `DPU_KEY_B3;
      default: key_byte = 8'h00;
    endcase
  end

  // unlock sequencer, takes key bytes only while reset pin is held low, unlocks on release
  always @(posedge mclk) begin
    if (srst) begin
      ust_q <= U_WAIT;
      key_idx_q <= 3'h0;
      settle_q <= 32'h0;
      rst_held_q <= 1'b0;
      pin_unlocked_q <= (SMALL_PKG == 0); // large package: always debug
    end else begin
      rst_held_q <= rst_held;
      case (ust_q)
        U_WAIT: begin
          // bytes before the internal reset settles are not trusted
          if (!rst_held)
            settle_q <= 32'h0;
          else if (settle_q >= SETTLE_CYC - 1)
            ust_q <= U_BAUD;
          else
            settle_q <= settle_q + 1'b1;
        end
        U_BAUD: begin
          if (!rst_held)
            ust_q <= U_FAIL;
          else if (rx_baud_ok) begin
            ust_q <= U_KEY;
            key_idx_q <= 3'h0;
          end
        end
        U_KEY: begin
          if (!rst_held)
            ust_q <= U_FAIL; // early release
          else if (rx_vld) begin
            if (rx_byte != key_byte)
              ust_q <= U_FAIL;
            else if (key_idx_q == `DPU_KEY_LEN - 1'b1)
              ust_q <= U_DONE;
            else
              key_idx_q <= key_idx_q + 1'b1;
          end
        end
        U_DONE: begin
          // takes effect on release of reset
          if (!rst_held)
            pin_unlocked_q <= 1'b1;
        end
        U_FAIL: begin
          // stays gpio until the next reset press
          if (rst_held && !rst_held_q) begin
            ust_q <= U_WAIT;
            settle_q <= 32'h0;
          end
        end
        default: ust_q <= U_WAIT;
      endcase
      // a new reset press never relocks; U_DONE and the unlock hold until srst
      if (rst_held && !rst_held_q && ust_q == U_DONE)
        ust_q <= U_DONE;
    end
  end

  // pin driver: gpio until unlocked, then open-drain debug transmit
  always @(posedge mclk) begin
    if (srst) begin
      shared_debug_gpio_pin_out <= 1'b1;
      shared_debug_gpio_pin_oe_n <= 1'b1;
    end else if (pin_unlocked_q) begin
      shared_debug_gpio_pin_out <= 1'b0;
      shared_debug_gpio_pin_oe_n <= !ocd_tx_low; // open drain, releases high
    end else begin
      shared_debug_gpio_pin_out <= gpio_out;
      shared_debug_gpio_pin_oe_n <= gpio_oe_n;
    end
  end

  // debug mode, break handling and opcode path
  always @(posedge mclk) begin
    if (srst) begin
      debug_mode_q <= 1'b0;
      cpu_idle_q <= 1'b0;
      exec_opcode_q <= 8'h00;
      illegal_op_q <= 1'b0;
      break_seen_q <= 1'b0;
      rx_byte_q <= 8'h00;
      rx_byte_vld_q <= 1'b0;
    end else begin
      rx_byte_vld_q <= pin_unlocked_q && rx_vld;
      rx_byte_q <= rx_vld ? rx_byte : rx_byte_q;
      // break recognised regardless of own transmission
      break_seen_q <= pin_unlocked_q && rx_break;
      illegal_op_q <= 1'b0;
      // software control write enters debug mode
      if (pin_unlocked_q && ctrl_wr && ctrl_wr_data == `DPU_CTRL_DEBUG) begin
        debug_mode_q <= 1'b1;
        cpu_idle_q <= 1'b1;
      end
      if (fetch_vld && !cpu_idle_q) begin
        if (fetch_opcode == `DPU_OPC_BREAK) begin
          // decoded break signals the debug unit only while bp_enable is set
          if (bp_enable) begin
            debug_mode_q <= 1'b1;
            cpu_idle_q <= 1'b1;
            exec_opcode_q <= `DPU_OPC_NOP;
          end else
            exec_opcode_q <= `DPU_OPC_NOP; // ignored, nop
        end else if (fetch_opcode == `DPU_OPC_ILLEGAL) begin
          // erased flash: flag illegal, never halts the debug link
          illegal_op_q <= 1'b1;
          exec_opcode_q <= `DPU_OPC_NOP;
        end else
          exec_opcode_q <= fetch_opcode;
      end
    end
  end
endmodule // dpu_unlock
`default_nettype wire

// ---- sim/dpu_unlock_asserts.sv ----
/* checker for the debug pin unlock block.
   assumes bind to dpu_unlock, one clock domain on mclk. */
`default_nettype none
module dpu_unlock_asserts (
  input wire logic mclk,
  input wire logic srst,
  input wire logic shared_reset_pin_n,
  input wire logic shared_debug_gpio_pin_in,
  input wire logic gpio_oe_n,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wr_data,
  input wire logic bp_enable,
  input wire logic [7:0] fetch_opcode,
  input wire logic fetch_vld,
  input wire logic shared_debug_gpio_pin_oe_n,
  input wire logic gpio_in,
  input wire logic pin_unlocked_q,
  input wire logic debug_mode_q,
  input wire logic cpu_idle_q,
  input wire logic [7:0] exec_opcode_q,
  input wire logic illegal_op_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // decoded break, split by breakpoint enable
  wire break_instruction = fetch_vld && fetch_opcode == 8'h00;
  a_break_enters_debug: assert property (break_instruction && bp_enable |=> debug_mode_q && cpu_idle_q)
    else $error("break with breakpoints on missed debug");
  a_break_as_nop: assert property (break_instruction && !bp_enable && !ctrl_wr |=>
    exec_opcode_q == 8'h0F && !$rose(debug_mode_q)) else $error("break not a nop");
  a_erased_illegal: assert property (fetch_vld && fetch_opcode == 8'hFF |=>
    illegal_op_q && exec_opcode_q == 8'h0F) else $error("ffh not illegal");
  a_unlock_on_release: assert property ($rose(pin_unlocked_q) |-> shared_reset_pin_n)
    else $error("unlock while reset pin held");
  a_unlock_stands: assert property (pin_unlocked_q |=> pin_unlocked_q)
    else $error("unlock lost without srst");
  a_gpio_in_path: assert property (gpio_in == (pin_unlocked_q || shared_debug_gpio_pin_in))
    else $error("gpio input path wrong");
  // registered pin drive: one cycle behind the gpio request while locked
  a_gpio_drive: assert property (!pin_unlocked_q && !$past(srst) |->
    shared_debug_gpio_pin_oe_n == $past(gpio_oe_n)) else $error("gpio drive lost");
  a_ctrl_enters: assert property (ctrl_wr && ctrl_wr_data == 8'h80 && pin_unlocked_q
    |=> debug_mode_q) else $error("control write missed debug");
  a_ctrl_locked: assert property (ctrl_wr && !pin_unlocked_q && !debug_mode_q && !fetch_vld
    |=> !debug_mode_q) else $error("locked pin entered debug");
  c_unlock: cover property ($rose(pin_unlocked_q));
  c_break: cover property (break_instruction && bp_enable);
  c_illegal: cover property (illegal_op_q);
endmodule // dpu_unlock_asserts
bind dpu_unlock dpu_unlock_asserts dpu_unlock_asserts_i (.*);
`default_nettype wire

// ---- sim/dpu_host_model.sv ----
/* debug host model: reset pin and open-drain serial line.
   assumes the bench resolves the line with a pull-up. */
`default_nettype none
module dpu_host_model #(
  parameter int BIT_CYC = 16,
  parameter int SETTLE = 100
) (
  input wire logic mclk,
  output var logic host_low,
  output var logic rst_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    host_low = 1'b0;
    rst_pin_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // hold reset through the settle time before any byte
  task automatic hold_reset;
    rst_pin_n = 1'b0;
    tick(SETTLE);
  endtask
  // let go of the reset pin; the unlock takes effect on this edge
  task automatic release_reset;
    rst_pin_n = 1'b1;
  endtask
  // 8n1, lsb first; only ever pulls low, release lets pull-up win
  task automatic send_byte(input logic [7:0] b);
    host_low = 1'b1;
    tick(BIT_CYC);
    for (int i = 0; i < 8; i++) begin
      host_low = !b[i];
      tick(BIT_CYC);
    end
    host_low = 1'b0;
    tick(2 * BIT_CYC);
  endtask
  // low run well past the break threshold
  task automatic send_break;
    host_low = 1'b1;
    tick(14 * BIT_CYC);
    host_low = 1'b0;
    tick(2 * BIT_CYC);
  endtask
endmodule // dpu_host_model
`default_nettype wire

// ---- sim/testbench.sv ----
/* self-checking bench for dpu_unlock with the host model.
   assumes a short settle parameter and a pulled-up debug line. */
`include "dpu_defs.vh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, srst, ocd_tx_low, ctrl_wr, bp_enable, fetch_vld;
  logic gpio_out, gpio_oe_n, brk_hit = 0, vld_hit = 0;
  logic [7:0] ctrl_wr_data, fetch_opcode, rx_byte_q, exec_opcode_q;
  wire host_low, rst_pin_n, pin_out, pin_oe_n, gpio_in, unl, dbg, idle, ill, brk_seen;
  wire dsp, rx_vld;
  int checked = 0, miscompares = 0, cyc = 0;
  // open drain line: low if anyone pulls, else pull-up
  wire line = !(host_low || ocd_tx_low || (!pin_oe_n && !pin_out));
  always #2.5 mclk = !mclk;
  dpu_host_model host_i (.mclk(mclk), .host_low(host_low), .rst_pin_n(rst_pin_n));
  dpu_unlock #(.SETTLE_CYC(100)) dpu_unlock_i (.mclk(mclk), .srst(srst),
    .shared_reset_pin_n(rst_pin_n), .shared_debug_gpio_pin_in(line), .gpio_out(gpio_out),
    .gpio_oe_n(gpio_oe_n), .ocd_tx_low(ocd_tx_low), .ctrl_wr_data(ctrl_wr_data),
    .ctrl_wr(ctrl_wr), .bp_enable(bp_enable), .fetch_opcode(fetch_opcode),
    .fetch_vld(fetch_vld), .shared_debug_gpio_pin_out(pin_out),
    .shared_debug_gpio_pin_oe_n(pin_oe_n), .gpio_in(gpio_in), .debug_serial_pin(dsp),
    .pin_unlocked_q(unl), .debug_mode_q(dbg), .cpu_idle_q(idle), .exec_opcode_q(exec_opcode_q),
    .illegal_op_q(ill), .break_seen_q(brk_seen), .rx_byte_q(rx_byte_q), .rx_byte_vld_q(rx_vld));
  // sticky capture, the break and byte pulses last one cycle
  always @(posedge mclk) begin
    if (brk_seen === 1'b1) brk_hit <= 1'b1;
    if (rx_vld === 1'b1) vld_hit <= 1'b1;
  end
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one-cycle pulse on the opcode or control strobe
  // leading idle cycle keeps back-to-back strobes apart
  task automatic fetch(input logic [7:0] op);
    host_i.tick(1);
    fetch_opcode = op;
    fetch_vld = 1;
    host_i.tick(1);
    fetch_vld = 0;
  endtask
  task automatic ctrl(input logic [7:0] d);
    host_i.tick(1);
    ctrl_wr_data = d;
    ctrl_wr = 1;
    host_i.tick(1);
    ctrl_wr = 0;
  endtask
  // reset pin low, settle, bytes, release; n bytes of the sequence
  task automatic unlock_try(input logic [7:0] k2, input int n);
    logic [7:0] s[5];
    s = '{`DPU_AUTOBAUD_BYTE, `DPU_KEY_B0, `DPU_KEY_B1, k2, `DPU_KEY_B3};
    host_i.hold_reset();
    for (int i = 0; i < n; i++) host_i.send_byte(s[i]);
    host_i.release_reset();
    host_i.tick(4);
  endtask
  task automatic t_locked;
    check("unlocked", unl, 0);
    gpio_oe_n = 0;
    gpio_out = 0;
    host_i.tick(2);
    check("gpio_in", gpio_in, 0);
    check("pin oe", pin_oe_n, 0);
    check("debug pin", dsp, 1);
    gpio_oe_n = 1;
    host_i.tick(2);
    $display("t_locked done");
  endtask
  task automatic t_opcodes;
    fetch(`DPU_OPC_BREAK);
    check("nop", exec_opcode_q, `DPU_OPC_NOP);
    check("debug", dbg, 0);
    fetch(`DPU_OPC_ILLEGAL);
    check("illegal", ill, 1);
    $display("t_opcodes done");
  endtask
  task automatic t_bad_keys;
    unlock_try(8'h71, 5);
    check("bad key", unl, 0);
    ctrl(`DPU_CTRL_DEBUG);
    check("debug", dbg, 0);
    unlock_try(`DPU_KEY_B2, 3);
    check("early", unl, 0);
    check("rx valid", vld_hit, 0);
    $display("t_bad_keys done");
  endtask
  task automatic t_unlock;
    unlock_try(`DPU_KEY_B2, 5);
    check("unlocked", unl, 1);
    check("gpio_in", gpio_in, 1);
    host_i.send_byte(`DPU_AUTOBAUD_BYTE);
    host_i.send_byte(`DPU_CTRL_DEBUG);
    check("rx byte", rx_byte_q, `DPU_CTRL_DEBUG);
    check("rx valid", vld_hit, 1);
    ctrl(`DPU_CTRL_DEBUG);
    check("debug", dbg, 1);
    ocd_tx_low = 1;
    host_i.tick(2);
    check("pin oe", pin_oe_n, 0);
    check("debug pin", dsp, 0);
    fork
      host_i.send_break();
      host_i.tick(48);
    join_any
    ocd_tx_low = 0;
    wait fork;
    check("break", brk_hit, 1);
    $display("t_unlock done");
  endtask
  task automatic t_break_on;
    srst = 1;
    host_i.tick(1);
    srst = 0;
    fetch(8'h52);
    check("legal", exec_opcode_q, 8'h52);
    bp_enable = 1;
    fetch(`DPU_OPC_BREAK);
    check("debug", dbg, 1);
    check("idle", idle, 1);
    $display("t_break_on done");
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    mclk = 1'b0;
    srst = 1'b1;
    ocd_tx_low = 1'b0;
    ctrl_wr = 1'b0;
    bp_enable = 1'b0;
    fetch_vld = 1'b0;
    gpio_out = 1'b1;
    gpio_oe_n = 1'b1;
    ctrl_wr_data = 8'h00;
    fetch_opcode = 8'h00;
    repeat (4) @(negedge mclk);
    srst = 0;
    host_i.tick(2);
    t_locked();
    t_opcodes();
    t_bad_keys();
    t_unlock();
    t_break_on();
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
